//--- hw/tlp_line_port.sv
// sixteen-port tdm line interface with fifo, per-port timing and registers
//
// Operation
// - sixteen independent ports, own rx and tx pins
// - rx data and marker sampled on chosen edge
// - gapped clock: every rx edge gives a bit
// - continuous clock: drop framing overhead bits only
// - clear e1: every bit taken, marker ignored
// - t1: bit at marker is discarded
// - e1: drop slot zero and slot sixteen
// - tx data and marker launched on chosen edge
// - no cell bits in tx overhead positions
// - tx marker pin direction set by control
// - tx marker pin is input after reset
// - t1: tx marker on first bit, no payload
// - e1: no tx payload in slots zero, sixteen
// - one tx marker per frame, either driver
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module tlp_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0] wr_q;
  logic [PW:0] rd_q;
  logic push;
  logic pop;
  assign o_in_ready = (wr_q - rd_q) != (PW+1)'(DEPTH);
  assign o_out_valid = wr_q != rd_q;
  assign o_out_data = mem_q[rd_q[PW-1:0]];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always_ff @(posedge i_mclk)
  begin
    if (push)
    begin
      mem_q[wr_q[PW-1:0]] <= i_in_data;
    end
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_q + (PW+1)'(push);
      rd_q <= rd_q + (PW+1)'(pop);
    end
  end
endmodule

module tlp_port #(
  parameter int DEPTH = tlp_pkg::FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_rx_clk,
  input wire logic i_rx_data,
  input wire logic i_rx_marker,
  input wire logic i_tx_clk,
  input wire logic i_tx_marker,
  output logic o_tx_data,
  output logic o_tx_marker,
  output logic o_tx_marker_oe,
  output logic o_rx_bit,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  input wire logic i_tx_bit,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic i_wr_rx,
  input wire logic i_wr_tx,
  input wire logic i_clr_ovr,
  input wire logic [tlp_pkg::DW-1:0] i_wdata,
  output logic [tlp_pkg::DW-1:0] o_rx_ctl,
  output logic [tlp_pkg::DW-1:0] o_tx_ctl,
  output logic [tlp_pkg::DW-1:0] o_status
);
  logic [tlp_pkg::DW-1:0] rx_control_two_q;
  logic [tlp_pkg::DW-1:0] tx_control_two_q;
  logic [2:0] rxc_s_q;
  logic [1:0] rxd_s_q;
  logic [1:0] rxm_s_q;
  logic [2:0] txc_s_q;
  logic [1:0] txm_s_q;
  logic rx_edge;
  logic tx_launch;
  tlp_pkg::tlp_mode_t rx_mode;
  tlp_pkg::tlp_mode_t tx_mode;
  logic rx_gapped_clock_mode;
  logic tx_marker_direction;
  logic [tlp_pkg::POS_W-1:0] rx_pos_q;
  logic [tlp_pkg::POS_W-1:0] rx_cur;
  logic rx_ovh;
  logic rx_push_q;
  logic rx_bit_q;
  logic rx_in_ready;
  logic overrun_q;
  logic [tlp_pkg::LOCK_W-1:0] lock_cnt_q;
  logic lock_q;
  logic [tlp_pkg::POS_W-1:0] tx_pos_q;
  logic [tlp_pkg::POS_W-1:0] tx_cur;
  logic tx_ovh;
  logic tx_pop;
  logic tx_fifo_valid;
  logic tx_fifo_bit;
  logic tx_data_q;
  logic tx_marker_q;
  logic tx_oe_q;

  // slot of a bit position is its upper five bits
  function automatic logic overhead(input tlp_pkg::tlp_mode_t m,
                                    input logic [tlp_pkg::POS_W-1:0] p);
    logic [4:0] slot;
    slot = p[tlp_pkg::POS_W-1:tlp_pkg::SLOT_LSB];
    overhead = 1'b0;
    if (m == tlp_pkg::TLP_T1)
    begin
      overhead = p == tlp_pkg::POS_FIRST;
    end
    else if (m == tlp_pkg::TLP_E1)
    begin
      overhead = slot == tlp_pkg::SLOT_ZERO || slot == tlp_pkg::SLOT_SIXTEEN;
    end
  endfunction

  function automatic logic [tlp_pkg::POS_W-1:0] next_pos(
      input tlp_pkg::tlp_mode_t m, input logic [tlp_pkg::POS_W-1:0] p);
    if (m == tlp_pkg::TLP_T1 && p == tlp_pkg::T1_LAST)
    begin
      next_pos = tlp_pkg::POS_FIRST;
    end
    else
    begin
      next_pos = p + tlp_pkg::POS_ONE;
    end
  endfunction

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      rx_control_two_q <= tlp_pkg::CTL_RESET;
      tx_control_two_q <= tlp_pkg::CTL_RESET;
    end
    else
    begin
      if (i_wr_rx)
      begin
        rx_control_two_q <= i_wdata & tlp_pkg::CTL_MASK;
      end
      if (i_wr_tx)
      begin
        tx_control_two_q <= i_wdata & tlp_pkg::CTL_MASK;
      end
    end
  end
  assign rx_mode = tlp_pkg::tlp_mode_t'(rx_control_two_q[tlp_pkg::CTL_MODE_LSB+:2]);
  assign tx_mode = tlp_pkg::tlp_mode_t'(tx_control_two_q[tlp_pkg::CTL_MODE_LSB+:2]);
  assign rx_gapped_clock_mode = rx_control_two_q[tlp_pkg::CTL_GAP_BIT];
  assign tx_marker_direction = tx_control_two_q[tlp_pkg::CTL_DIR_BIT];

  // line pins are asynchronous; stage 2 of the clocks is edge history only
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      rxc_s_q <= '0;
      rxd_s_q <= '0;
      rxm_s_q <= '0;
      txc_s_q <= '0;
      txm_s_q <= '0;
    end
    else
    begin
      rxc_s_q <= {rxc_s_q[1:0], i_rx_clk};
      rxd_s_q <= {rxd_s_q[0], i_rx_data};
      rxm_s_q <= {rxm_s_q[0], i_rx_marker};
      txc_s_q <= {txc_s_q[1:0], i_tx_clk};
      txm_s_q <= {txm_s_q[0], i_tx_marker};
    end
  end
  assign rx_edge = rx_control_two_q[tlp_pkg::CTL_EDGE_BIT] ?
                   (!rxc_s_q[1] && rxc_s_q[2]) : (rxc_s_q[1] && !rxc_s_q[2]);
  assign tx_launch = tx_control_two_q[tlp_pkg::CTL_EDGE_BIT] ?
                     (!txc_s_q[1] && txc_s_q[2]) : (txc_s_q[1] && !txc_s_q[2]);

  // the marker bit is position zero of the frame
  assign rx_cur = rxm_s_q[1] ? tlp_pkg::POS_FIRST : rx_pos_q;
  assign rx_ovh = !rx_gapped_clock_mode && overhead(rx_mode, rx_cur);

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      rx_pos_q <= tlp_pkg::POS_FIRST;
      rx_push_q <= 1'b0;
      rx_bit_q <= 1'b0;
    end
    else
    begin
      rx_push_q <= rx_edge && !rx_ovh;
      if (rx_edge)
      begin
        rx_pos_q <= next_pos(rx_mode, rx_cur);
        rx_bit_q <= rxd_s_q[1];
      end
    end
  end

  // the line cannot be stalled: a bit that meets a full fifo is lost
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      overrun_q <= 1'b0;
    end
    else if (rx_push_q && !rx_in_ready)
    begin
      overrun_q <= 1'b1;
    end
    else if (i_clr_ovr)
    begin
      overrun_q <= 1'b0;
    end
  end

  // lock drops after two frame periods with no marker
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      lock_cnt_q <= '0;
      lock_q <= 1'b0;
    end
    else if (rx_edge && rxm_s_q[1])
    begin
      lock_cnt_q <= '0;
      lock_q <= 1'b1;
    end
    else if (lock_cnt_q == tlp_pkg::LOCK_LIMIT)
    begin
      lock_q <= 1'b0;
    end
    else
    begin
      lock_cnt_q <= lock_cnt_q + 1'b1;
    end
  end

  tlp_fifo #(.WIDTH(1), .DEPTH(DEPTH)) u_rx_fifo (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_in_valid(rx_push_q),
    .o_in_ready(rx_in_ready),
    .i_in_data(rx_bit_q),
    .o_out_valid(o_rx_valid),
    .i_out_ready(i_rx_ready),
    .o_out_data(o_rx_bit)
  );

  // input marker restarts the frame; output marker follows our own count
  assign tx_cur = (!tx_marker_direction && txm_s_q[1]) ? tlp_pkg::POS_FIRST : tx_pos_q;
  assign tx_ovh = overhead(tx_mode, tx_cur);
  assign tx_pop = tx_launch && !tx_ovh;

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      tx_pos_q <= tlp_pkg::POS_FIRST;
      tx_data_q <= 1'b1;
      tx_marker_q <= 1'b0;
    end
    else if (tx_launch)
    begin
      tx_pos_q <= next_pos(tx_mode, tx_cur);
      // underrun sends ones, overhead sends zero
      tx_data_q <= tx_ovh ? 1'b0 : (tx_fifo_valid ? tx_fifo_bit : 1'b1);
      tx_marker_q <= tx_marker_direction && tx_cur == tlp_pkg::POS_FIRST;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      tx_oe_q <= 1'b0;
    end
    else
    begin
      tx_oe_q <= tx_marker_direction;
    end
  end

  tlp_fifo #(.WIDTH(1), .DEPTH(DEPTH)) u_tx_fifo (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_in_valid(i_tx_valid),
    .o_in_ready(o_tx_ready),
    .i_in_data(i_tx_bit),
    .o_out_valid(tx_fifo_valid),
    .i_out_ready(tx_pop),
    .o_out_data(tx_fifo_bit)
  );

  assign o_tx_data = tx_data_q;
  assign o_tx_marker = tx_marker_q;
  assign o_tx_marker_oe = tx_oe_q;
  assign o_rx_ctl = rx_control_two_q;
  assign o_tx_ctl = tx_control_two_q;
  always_comb
  begin
    o_status = '0;
    o_status[tlp_pkg::STS_RX_AVAIL] = o_rx_valid;
    o_status[tlp_pkg::STS_TX_FULL] = !o_tx_ready;
    o_status[tlp_pkg::STS_LOCK] = lock_q;
    o_status[tlp_pkg::STS_OVERRUN] = overrun_q;
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_rx_t1_marker;
    rx_edge && rx_mode == tlp_pkg::TLP_T1 && !rx_gapped_clock_mode && rxm_s_q[1];
  endsequence
  sequence s_rx_e1_slot16;
    rx_edge && rx_mode == tlp_pkg::TLP_E1 && !rx_gapped_clock_mode &&
    rx_cur[tlp_pkg::POS_W-1:tlp_pkg::SLOT_LSB] == tlp_pkg::SLOT_SIXTEEN;
  endsequence
  sequence s_tx_ovh_launch;
    tx_launch && tx_ovh;
  endsequence
  sequence s_tx_out_marker;
    tx_launch && tx_marker_direction && tx_cur == tlp_pkg::POS_FIRST;
  endsequence

  AST_RX_T1_DROP: assert property (s_rx_t1_marker |=> !rx_push_q)
    else $error("t1 marker bit was pushed");
  AST_RX_E1_DROP: assert property (s_rx_e1_slot16 |=> !rx_push_q)
    else $error("e1 slot sixteen bit was pushed");
  AST_RX_GAPPED: assert property (rx_edge && rx_gapped_clock_mode |=> rx_push_q)
    else $error("gapped clock edge lost a bit");
  AST_RX_CLEAR: assert property (rx_edge && rx_mode == tlp_pkg::TLP_CE1 |=> rx_push_q)
    else $error("clear e1 edge lost a bit");
  AST_RX_DATA: assert property (rx_edge ##1 rx_push_q |-> rx_bit_q == $past(rxd_s_q[1]))
    else $error("pushed bit differs from sampled data");
  AST_TX_OVH: assert property (s_tx_ovh_launch |-> !tx_pop ##1 !tx_data_q)
    else $error("payload placed in overhead");
  AST_TX_T1_FIRST: assert property (tx_launch && tx_mode == tlp_pkg::TLP_T1 &&
    tx_cur == tlp_pkg::POS_FIRST |=> !tx_data_q)
    else $error("t1 first bit carried payload");
  AST_TX_MARKER: assert property (s_tx_out_marker |=> tx_marker_q ##1
    (tx_marker_q throughout (!tx_launch [*1])))
    else $error("output marker not raised with first bit");
  AST_TX_MARKER_NARROW: assert property (tx_marker_q && tx_launch |=> !tx_marker_q)
    else $error("output marker wider than one bit");
  AST_DIR: assert property (tx_marker_direction != tx_oe_q |=> tx_oe_q == $past(tx_marker_direction))
    else $error("marker direction not applied");
  AST_DIR_RESET: assert property (@(posedge i_mclk) $fell(i_rst) |-> !tx_oe_q)
    else $error("marker pin not input after reset");
endmodule

module tlp_line_port #(
  parameter int NPORTS = tlp_pkg::NPORTS,
  parameter int DEPTH = tlp_pkg::FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [NPORTS-1:0] i_rx_line_clock,
  input wire logic [NPORTS-1:0] i_rx_line_data,
  input wire logic [NPORTS-1:0] i_rx_frame_marker,
  input wire logic [NPORTS-1:0] i_tx_line_clock,
  input wire logic [NPORTS-1:0] i_tx_frame_marker,
  output logic [NPORTS-1:0] o_tx_frame_marker,
  output logic [NPORTS-1:0] o_tx_frame_marker_oe,
  output logic [NPORTS-1:0] o_tx_line_data,
  output logic [NPORTS-1:0] o_rx_bit,
  output logic [NPORTS-1:0] o_rx_valid,
  input wire logic [NPORTS-1:0] i_rx_ready,
  input wire logic [NPORTS-1:0] i_tx_bit,
  input wire logic [NPORTS-1:0] i_tx_valid,
  output logic [NPORTS-1:0] o_tx_ready,
  input wire logic [tlp_pkg::AW-1:0] i_reg_addr,
  input wire logic [tlp_pkg::DW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [tlp_pkg::DW-1:0] o_reg_rdata
);
  logic [tlp_pkg::DW-1:0] rx_ctl [NPORTS];
  logic [tlp_pkg::DW-1:0] tx_ctl [NPORTS];
  logic [tlp_pkg::DW-1:0] sts [NPORTS];
  logic [1:0] region;
  logic [tlp_pkg::IDX_W-1:0] idx;
  logic [tlp_pkg::DW-1:0] rdata_q;
  assign region = i_reg_addr[tlp_pkg::AW-1:tlp_pkg::IDX_W];
  assign idx = i_reg_addr[tlp_pkg::IDX_W-1:0];

  for (genvar p = 0; p < NPORTS; p++)
  begin : g_port
    tlp_port #(.DEPTH(DEPTH)) u_port (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_rx_clk(i_rx_line_clock[p]),
      .i_rx_data(i_rx_line_data[p]),
      .i_rx_marker(i_rx_frame_marker[p]),
      .i_tx_clk(i_tx_line_clock[p]),
      .i_tx_marker(i_tx_frame_marker[p]),
      .o_tx_data(o_tx_line_data[p]),
      .o_tx_marker(o_tx_frame_marker[p]),
      .o_tx_marker_oe(o_tx_frame_marker_oe[p]),
      .o_rx_bit(o_rx_bit[p]),
      .o_rx_valid(o_rx_valid[p]),
      .i_rx_ready(i_rx_ready[p]),
      .i_tx_bit(i_tx_bit[p]),
      .i_tx_valid(i_tx_valid[p]),
      .o_tx_ready(o_tx_ready[p]),
      .i_wr_rx(i_reg_wr && region == tlp_pkg::REG_RX_CTL && idx == p),
      .i_wr_tx(i_reg_wr && region == tlp_pkg::REG_TX_CTL && idx == p),
      .i_clr_ovr(i_reg_wr && region == tlp_pkg::REG_STATUS && idx == p &&
                 i_reg_wdata[tlp_pkg::STS_OVERRUN]),
      .i_wdata(i_reg_wdata),
      .o_rx_ctl(rx_ctl[p]),
      .o_tx_ctl(tx_ctl[p]),
      .o_status(sts[p])
    );
  end

  // unmapped addresses and ports beyond NPORTS read as zero
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || !i_reg_rd || 32'(idx) >= NPORTS)
    begin
      rdata_q <= '0;
    end
    else if (region == tlp_pkg::REG_RX_CTL)
    begin
      rdata_q <= rx_ctl[idx];
    end
    else if (region == tlp_pkg::REG_TX_CTL)
    begin
      rdata_q <= tx_ctl[idx];
    end
    else if (region == tlp_pkg::REG_STATUS)
    begin
      rdata_q <= sts[idx];
    end
    else
    begin
      rdata_q <= '0;
    end
  end
  assign o_reg_rdata = rdata_q;
endmodule
`default_nettype wire

//--- inc/tlp_pkg.sv
// constants and types for the tdm line port block
`default_nettype none
package tlp_pkg;
  localparam int NPORTS = 16;
  localparam int DW = 8;
  localparam int AW = 6;
  localparam int IDX_W = 4;
  localparam int FIFO_DEPTH = 8;
  // register regions, selected by the two top address bits
  localparam logic [1:0] REG_RX_CTL = 2'h0;
  localparam logic [1:0] REG_TX_CTL = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [DW-1:0] CTL_RESET = 8'h00;
  localparam logic [DW-1:0] CTL_MASK = 8'h35;
  localparam int CTL_GAP_BIT = 0;
  localparam int CTL_DIR_BIT = 0;
  localparam int CTL_EDGE_BIT = 2;
  localparam int CTL_MODE_LSB = 4;
  localparam int STS_RX_AVAIL = 0;
  localparam int STS_TX_FULL = 1;
  localparam int STS_LOCK = 2;
  localparam int STS_OVERRUN = 3;
  typedef enum logic [1:0] {
    TLP_T1 = 2'b00,
    TLP_E1 = 2'b01,
    TLP_CE1 = 2'b10
  } tlp_mode_t;
  localparam int POS_W = 8;
  localparam logic [POS_W-1:0] POS_FIRST = 8'h00;
  localparam logic [POS_W-1:0] POS_ONE = 8'h01;
  localparam logic [POS_W-1:0] T1_LAST = 8'hC0;
  localparam int SLOT_LSB = 3;
  localparam logic [4:0] SLOT_ZERO = 5'h00;
  localparam logic [4:0] SLOT_SIXTEEN = 5'h10;
  localparam int FRAME_NS = 125000;
  localparam int CLK_NS = 100;
  localparam int FRAME_CYC = FRAME_NS / CLK_NS;
  localparam int LOCK_W = 12;
  localparam logic [LOCK_W-1:0] LOCK_LIMIT = LOCK_W'(2 * FRAME_CYC - 1);
endpackage
`default_nettype wire

//--- verification/tlp_framer_model.sv
// behavioural line framer driving the rx and tx line pins of every port
`timescale 1ns/100ps
`default_nettype none
module tlp_framer_model (
  input wire logic i_go,
  input wire logic [3:0] i_frames,
  input wire logic i_e1,
  input wire logic i_gap,
  input wire logic i_fall,
  output logic o_busy,
  output logic o_clk,
  output logic o_data,
  output logic o_marker
);
  initial
  begin
    o_busy = 1'b0;
    o_clk = 1'b0;
    o_data = 1'b0;
    o_marker = 1'b0;
  end
  // lines valid only 300 ns around the sampling edge, inverted elsewhere
  task automatic send_bit(input int p);
    logic ovh;
    logic d;
    logic m;
    logic run;
    ovh = i_e1 ? (p / 8 == 0 || p / 8 == 16) : (p == 0);
    d = ovh | p[0];
    m = (p == 0) & ~i_gap;
    run = !(i_gap && ovh);
    if (run)
      o_clk = i_fall;
    #100;
    o_data = d;
    o_marker = m;
    #300;
    if (run)
      o_clk = ~i_fall;
    #300;
    o_data = ~d;
    o_marker = ~m;
    #100;
  endtask
  // clock stands still between runs
  always @(posedge i_go)
  begin
    o_busy = 1'b1;
    #37;
    for (int f = 0; f < int'(i_frames); f++)
      for (int p = 0; p < (i_e1 ? 256 : 193); p++)
        send_bit(p);
    o_busy = 1'b0;
  end
endmodule
`default_nettype wire

//--- verification/tb_tlp_line_port.sv
// self-checking bench for the tdm line port block
`timescale 1ns/100ps
`default_nettype none
module tb_tlp_line_port;
  localparam int N = tlp_pkg::NPORTS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [N-1:0] rx_ready = '1;
  logic [N-1:0] tx_bit = '0;
  logic [N-1:0] tx_valid = '0;
  logic [N-1:0] tx_oe, tx_mk, tx_data, rx_bit, rx_valid, tx_ready, tx_pin;
  logic go = 1'b0;
  logic e1 = 1'b0;
  logic gap = 1'b0;
  logic fall = 1'b0;
  logic [3:0] frames = 4'h0;
  logic busy, lclk, ldata, lmk;
  int num_errors = 0;
  int num_checks = 0;
  int pops = 0;
  int ones = 0;

  always #50 clk = ~clk;
  // two-way marker pin: device wins while it drives
  assign tx_pin = (tx_oe & tx_mk) | (~tx_oe & {N{lmk}});

  tlp_framer_model partner (.i_go(go), .i_frames(frames), .i_e1(e1), .i_gap(gap),
    .i_fall(fall), .o_busy(busy), .o_clk(lclk), .o_data(ldata), .o_marker(lmk));

  tlp_line_port dut (.i_mclk(clk), .i_rst(rst), .i_rx_line_clock({N{lclk}}),
    .i_rx_line_data({N{ldata}}), .i_rx_frame_marker({N{lmk}}),
    .i_tx_line_clock({N{lclk}}), .i_tx_frame_marker(tx_pin), .o_tx_frame_marker(tx_mk),
    .o_tx_frame_marker_oe(tx_oe), .o_tx_line_data(tx_data), .o_rx_bit(rx_bit),
    .o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .i_tx_bit(tx_bit),
    .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata));

  always @(posedge clk)
    if (rx_valid[0] && rx_ready[0])
    begin
      pops++;
      ones += int'(rx_bit[0]);
    end

  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic cfg(input logic [5:0] base, input logic [7:0] v);
    for (int p = 0; p < N; p++)
      reg_wr(base + 6'(p), v);
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic run_line(input logic [3:0] nf, input logic ie1, input logic ig, input logic f);
    int k;
    frames <= nf;
    e1 <= ie1;
    gap <= ig;
    fall <= f;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; busy !== 1'b0 && k < 30000; k++)
      @(posedge clk);
    if (k >= 30000)
    begin
      num_errors++;
      test_done();
    end
    repeat (10) @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    logic [7:0] d;
    chk("marker oe", 16'h0, 16'(tx_oe));
    chk("tx idle data", 16'hFFFF, 16'(tx_data));
    chk("rx valid", 16'h0, 16'(rx_valid));
    for (int a = 0; a < 64; a += 15)
    begin
      reg_rd(6'(a), d);
      chk("reset value", 16'h0, 16'(d));
    end
    reg_wr(6'h30, 8'hFF);
    reg_rd(6'h30, d);
    chk("unmapped", 16'h0, 16'(d));
    reg_wr(6'h1F, 8'hFF);
    reg_rd(6'h1F, d);
    chk("tx control", 16'(tlp_pkg::CTL_MASK), 16'(d));
  endtask

  task automatic t_rx(input logic [7:0] ctl, input logic ie1, input logic ig);
    int ep;
    int eo;
    logic o;
    ep = 0;
    eo = 0;
    for (int p = 0; p < (ie1 ? 256 : 193); p++)
    begin
      o = ie1 ? (p / 8 == 0 || p / 8 == 16) : (p == 0);
      if (ctl[5] || !o)
      begin
        ep += 2;
        eo += (o || p % 2 == 1) ? 2 : 0;
      end
    end
    cfg(6'h00, ctl);
    pops = 0;
    ones = 0;
    run_line(4'h2, ie1, ig, ctl[2]);
    chk("rx bit count", 16'(ep), 16'(pops));
    chk("rx ones count", 16'(eo), 16'(ones));
  endtask

  task automatic t_ovr();
    logic [7:0] d;
    cfg(6'h00, 8'h00);
    rx_ready <= '0;
    run_line(4'h1, 1'b0, 1'b0, 1'b0);
    chk("rx valid", 16'h1, 16'(rx_valid[0]));
    reg_rd(6'h20, d);
    chk("status", 16'h0D, 16'(d));
    reg_wr(6'h20, 8'h08);
    reg_rd(6'h20, d);
    chk("status", 16'h05, 16'(d));
    pops = 0;
    rx_ready <= '1;
    repeat (40) @(posedge clk);
    #1;
    chk("drained bits", 16'(tlp_pkg::FIFO_DEPTH), 16'(pops));
    chk("rx valid", 16'h0, 16'(rx_valid[0]));
  endtask

  task automatic t_tx(input logic [7:0] ctl, input int len);
    int k;
    int hi;
    int zer;
    logic fin;
    logic prev;
    cfg(6'h10, ctl);
    chk("marker oe", 16'hFFFF, 16'(tx_oe));
    fork
      run_line(4'h3, len == 256, 1'b0, ctl[2]);
      begin
        // wait for a fresh rise: a marker left high by the last run is stale
        prev = 1'b1;
        for (k = 0; !(tx_mk[0] === 1'b1 && prev === 1'b0) && k < 3000; k++)
        begin
          prev = tx_mk[0];
          @(posedge clk);
          #1;
        end
        if (k >= 3000)
        begin
          num_errors++;
          test_done();
        end
        chk("launch edge level", 16'(!ctl[2]), 16'(lclk));
        chk("data at marker", 16'h0, 16'(tx_data[0]));
        k = 0;
        hi = 1;
        zer = 0;
        fin = 1'b0;
        prev = 1'b1;
        while (!fin && k < 2100)
        begin
          @(posedge clk);
          #1;
          k++;
          fin = tx_mk[0] && !prev;
          prev = tx_mk[0];
          if (!fin)
            hi += int'(tx_mk[0]);
          if (k % 8 == 4)
            zer += int'(!tx_data[0]);
        end
        chk("frame period", 16'(len * 8), 16'(k));
        chk("marker width", 16'h8, 16'(hi));
        chk("overhead zeros", 16'(len == 256 ? 16 : 1), 16'(zer));
      end
    join
  endtask

  task automatic t_txfill();
    logic [7:0] d;
    tx_bit <= '0;
    tx_valid <= '1;
    repeat (12) @(posedge clk);
    tx_valid <= '0;
    #1;
    chk("tx ready full", 16'h0, 16'(tx_ready));
    reg_rd(6'h20, d);
    chk("tx full flag", 16'h1, 16'(d[1]));
    run_line(4'h1, 1'b0, 1'b0, 1'b0);
    chk("tx ready drained", 16'hFFFF, 16'(tx_ready));
    cfg(6'h10, 8'h00);
    chk("marker oe", 16'h0, 16'(tx_oe));
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rx(8'h00, 1'b0, 1'b0);
    t_rx(8'h14, 1'b1, 1'b0);
    t_rx(8'h20, 1'b1, 1'b0);
    t_rx(8'h01, 1'b0, 1'b1);
    t_ovr();
    t_tx(8'h01, 193);
    t_tx(8'h15, 256);
    t_txfill();
    test_done();
  end
endmodule
`default_nettype wire
